// File: clock_gen_cfg.svh
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

// register byte offsets within the block (low 12 address bits)
`define OFS_OC_ENABLE 12'h370
`define OFS_OC_DIVSEL 12'h374
`define OFS_SYS_STATUS 12'h378
`define OFS_SYS_DIVIDE_VALUE_FIELD 12'h37C
`define OFS_AUX0_SEL 12'h380
`define OFS_AUX1_SEL 12'h388
`define OFS_AUX1_DIVIDE_VALUE_FIELD 12'h38C
`define OFS_SYS_DIV1 12'h3A0
`define OFS_SYS_DIV2 12'h3A4

// field positions
`define DE_BIT 31
`define DIV_LO 24
`define SEL_LO 24
`define OUTPUT_DIVIDE_SELECT_FIELD_LO 28
`define OCEN_BIT 0

// field widths
`define SEL_W 4
`define DIV_W 4

// source codes of the auxiliary and output selects
`define SRC_XOSC 4'h0
`define SRC_IRC 4'h1
`define SRC_PLL 4'h2
`define SRC_SYS 4'h3
`define SRC_RTC 4'h4
`define SRC_PHI1 4'h5
`define AUX1_SYS 4'h0
`define AUX1_PHI1 4'h1

// system clock select and status codes
`define SYS_IRC 4'h0
`define SYS_XOSC 4'h2
`define SYS_PLL 4'h4
`define SYS_OFF 4'hF

// reset values
`define RST_SEL 4'h0
`define RST_DIV 4'h0
`define RST_CNT 4'h1
`define RST_OUTPUT_DIVIDE_SELECT_FIELD 2'h0

`endif

// File: clock_gen_pkg.sv
package clock_gen_pkg;
    typedef logic [3:0] sel_code_t;
    typedef logic [3:0] div_value_t;
    typedef logic [1:0] out_div_t;
endpackage

// File: clk_divider.sv
`timescale 1ns/100ps
`include "clock_gen_cfg.svh"

module clk_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic enable,
    input wire clock_gen_pkg::div_value_t divide,
    input wire logic src_level,
    input wire logic src_rise,
    output logic clk_out
);
    clock_gen_pkg::div_value_t cnt;
    clock_gen_pkg::div_value_t div_act;
    wire wrap = (cnt >= div_act);
    wire [3:0] next_cnt = wrap ? 4'h0 : 4'(cnt + 4'h1);

    // divide value is taken only at wrap, so a change never shortens a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= `RST_CNT;
            div_act <= `RST_DIV;
            clk_out <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                clk_out <= 1'b0;
            end else if (src_rise) begin
                cnt <= next_cnt;
                if (wrap) begin
                    div_act <= divide;
                end
                clk_out <= wrap;
            end else if (!src_level) begin
                clk_out <= 1'b0;
            end
        end
    end
endmodule

// File: clock_generation_unit.sv
`timescale 1ns/100ps
`include "clock_gen_cfg.svh"
// Function
// - aux clock 0 select: 0000 crystal, 0001 internal RC, others reserved.
// - selected aux clock 0 drives the PLL reference clock.
// - aux clock 1 select: 0000 system clock, 0001 PLL secondary output.
// - aux 1 divider enable bit: 0 disables, 1 enables.
// - network clock period is divide value plus one aux 1 periods.
// - while aux divider disabled, divide writes ignored and network clock stopped.
// - safe clock request forces system clock to internal RC.
// - reset unit controls system select on safe/reset, else mode entry unit.
// - mode entry may switch system clock off in deep stop and test.
// - three peripheral set clocks from system clock, own divider and register each.
// - unavailable aux select code keeps previous selection and register content.
// - every clk_divider counter resets to one; the output ripple counter resets to zero.
// - a disabled divider ignores its divide field.
// - output path multiplexes several sources chosen by division select register.
// - output pin carries ripple counter tap or undivided source.
// - output enable register bit turns the output pin on or off.
// - output divide select: 00 by 1, 01 by 2, 10 by 4, 11 by 8.
// - output source: 0000 crystal, 0001 RC, 0010 PLL, 0011 system clock.

module clock_generation_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_crystal_osc,
    input wire logic fast_internal_rc_osc,
    input wire logic freq_modulated_pll,
    input wire logic pll_secondary_output,
    input wire logic rtc_clock,
    input wire logic [3:0] sys_select,
    input wire logic sys_switch_mask,
    input wire logic sys_clock_off,
    input wire logic deep_stop_mode,
    input wire logic test_mode,
    input wire logic safe_clock_req,
    output logic system_clock,
    output logic [2:0] periph_set_clk,
    output logic pll_reference_clk,
    output logic network_clk,
    output logic clock_output_pin
);
    // source levels: 0 crystal, 1 RC, 2 PLL, 3 PLL secondary, 4 RTC
    logic [4:0] src_meta;
    logic [4:0] src_lvl;
    logic [4:0] src_dly;
    wire [4:0] src_rise = src_lvl & ~src_dly;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta <= 5'h00;
            src_lvl <= 5'h00;
            src_dly <= 5'h00;
        end else if (ce) begin
            src_meta <= {rtc_clock, pll_secondary_output, freq_modulated_pll,
                         fast_internal_rc_osc, fast_crystal_osc};
            src_lvl <= src_meta;
            src_dly <= src_lvl;
        end
    end

    // register file
    logic oc_en;
    clock_gen_pkg::out_div_t oc_output_divide_select_field;
    clock_gen_pkg::sel_code_t oc_sel;
    clock_gen_pkg::sel_code_t ac0_sel;
    clock_gen_pkg::sel_code_t ac1_sel;
    logic ac1_en;
    clock_gen_pkg::div_value_t ac1_div;
    logic [2:0] dc_en;
    clock_gen_pkg::div_value_t dc_div [3];
    clock_gen_pkg::sel_code_t sys_status;

    wire wr = psel && penable && pwrite && ce;
    wire [3:0] wsel = pwdata[`SEL_LO +: `SEL_W];
    wire [3:0] wdiv = pwdata[`DIV_LO +: `DIV_W];
    wire wde = pwdata[`DE_BIT];
    wire hit_ocen = (paddr == `OFS_OC_ENABLE);
    wire hit_ocds = (paddr == `OFS_OC_DIVSEL);
    wire hit_ss = (paddr == `OFS_SYS_STATUS);
    wire hit_ac0 = (paddr == `OFS_AUX0_SEL);
    wire hit_ac1 = (paddr == `OFS_AUX1_SEL);
    wire hit_acd = (paddr == `OFS_AUX1_DIVIDE_VALUE_FIELD);
    wire [2:0] hit_dc = {paddr == `OFS_SYS_DIV2, paddr == `OFS_SYS_DIV1, paddr == `OFS_SYS_DIVIDE_VALUE_FIELD};
    wire hit = hit_ocen | hit_ocds | hit_ss | hit_ac0 | hit_ac1 | hit_acd | (|hit_dc);
    wire ac0_ok = (wsel == `SRC_XOSC) || (wsel == `SRC_IRC);
    wire ac1_ok = (wsel == `AUX1_SYS) || (wsel == `AUX1_PHI1);
    wire oc_ok = (wsel <= `SRC_PHI1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_en <= 1'b0;
            oc_output_divide_select_field <= `RST_OUTPUT_DIVIDE_SELECT_FIELD;
            oc_sel <= `RST_SEL;
            ac0_sel <= `RST_SEL;
            ac1_sel <= `RST_SEL;
            ac1_en <= 1'b0;
            ac1_div <= `RST_DIV;
        end else if (wr) begin
            if (hit_ocen) begin
                oc_en <= pwdata[`OCEN_BIT];
            end
            if (hit_ocds && oc_ok) begin
                oc_output_divide_select_field <= pwdata[`OUTPUT_DIVIDE_SELECT_FIELD_LO +: 2];
                oc_sel <= wsel;
            end
            if (hit_ac0 && ac0_ok) begin
                ac0_sel <= wsel;
            end
            if (hit_ac1 && ac1_ok) begin
                ac1_sel <= wsel;
            end
            if (hit_acd) begin
                ac1_en <= wde;
                if (wde) begin
                    ac1_div <= wdiv;
                end
            end
        end
    end

    // the three peripheral set divider registers share one shape
    for (genvar i = 0; i < 3; i++) begin : g_dcreg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dc_en[i] <= 1'b0;
                dc_div[i] <= `RST_DIV;
            end else if (wr && hit_dc[i]) begin
                dc_en[i] <= wde;
                if (wde) begin
                    dc_div[i] <= wdiv;
                end
            end
        end
    end

    function automatic logic [31:0] sel_word(input logic [3:0] v);
        sel_word = {28'h0, v} << `SEL_LO;
    endfunction
    function automatic logic [31:0] div_word(input logic e, input logic [3:0] v);
        div_word = ({31'h0, e} << `DE_BIT) | ({28'h0, v} << `DIV_LO);
    endfunction

    wire [31:0] rd_word =
        hit_ocen ? ({31'h0, oc_en} << `OCEN_BIT) :
        hit_ocds ? (({30'h0, oc_output_divide_select_field} << `OUTPUT_DIVIDE_SELECT_FIELD_LO) | sel_word(oc_sel)) :
        hit_ss ? sel_word(sys_status) :
        hit_ac0 ? sel_word(ac0_sel) :
        hit_ac1 ? sel_word(ac1_sel) :
        hit_acd ? div_word(ac1_en, ac1_div) :
        hit_dc[0] ? div_word(dc_en[0], dc_div[0]) :
        hit_dc[1] ? div_word(dc_en[1], dc_div[1]) :
        hit_dc[2] ? div_word(dc_en[2], dc_div[2]) : 32'h0;

    // read data captured in the setup cycle, so no wait states are needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (ce && psel && !penable) begin
            prdata <= rd_word;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // system clock selection
    clock_gen_pkg::sel_code_t sys_target;
    clock_gen_pkg::sel_code_t sys_act;
    logic sys_off;
    wire sys_sel_ok = (sys_select == `SYS_IRC) || (sys_select == `SYS_XOSC) || (sys_select == `SYS_PLL);
    wire off_allowed = deep_stop_mode || test_mode;
    wire [3:0] next_target = safe_clock_req ? `SYS_IRC :
                             (!sys_switch_mask && sys_sel_ok) ? sys_select : sys_target;
    wire next_sys_off = sys_clock_off && off_allowed && !safe_clock_req;
    wire sys_src = (sys_act == `SYS_XOSC) ? src_lvl[0] :
                   (sys_act == `SYS_PLL) ? src_lvl[2] : src_lvl[1];
    wire sys_new = (sys_target == `SYS_XOSC) ? src_lvl[0] :
                   (sys_target == `SYS_PLL) ? src_lvl[2] : src_lvl[1];
    logic sys_dly;
    wire sys_rise = system_clock && !sys_dly;

    // switch only while output, old and new source are all low: no runt, no cut high phase;
    // a source stuck high blocks the switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_target <= `SYS_IRC;
            sys_act <= `SYS_IRC;
            sys_off <= 1'b0;
            system_clock <= 1'b0;
            sys_dly <= 1'b0;
        end else if (ce) begin
            sys_target <= next_target;
            sys_off <= next_sys_off;
            if (!system_clock && !sys_src && !sys_new) begin
                sys_act <= sys_target;
            end
            system_clock <= sys_src && !sys_off;
            sys_dly <= system_clock;
        end
    end
    assign sys_status = sys_off ? `SYS_OFF : sys_act;

    for (genvar i = 0; i < 3; i++) begin : g_psdiv
        clk_divider u_div (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .enable(dc_en[i]),
            .divide(dc_div[i]),
            .src_level(system_clock),
            .src_rise(sys_rise),
            .clk_out(periph_set_clk[i])
        );
    end

    // auxiliary clocks
    clock_gen_pkg::sel_code_t ac0_act;
    clock_gen_pkg::sel_code_t ac1_act;
    logic aux1_clk;
    logic aux1_dly;
    wire ac0_src = (ac0_act == `SRC_IRC) ? src_lvl[1] : src_lvl[0];
    wire ac1_src = (ac1_act == `AUX1_PHI1) ? src_lvl[3] : system_clock;
    wire ac0_new = (ac0_sel == `SRC_IRC) ? src_lvl[1] : src_lvl[0];
    wire ac1_new = (ac1_sel == `AUX1_PHI1) ? src_lvl[3] : system_clock;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac0_act <= `RST_SEL;
            ac1_act <= `RST_SEL;
            pll_reference_clk <= 1'b0;
            aux1_clk <= 1'b0;
            aux1_dly <= 1'b0;
        end else if (ce) begin
            if (!pll_reference_clk && !ac0_src && !ac0_new) begin
                ac0_act <= ac0_sel;
            end
            if (!aux1_clk && !ac1_src && !ac1_new) begin
                ac1_act <= ac1_sel;
            end
            pll_reference_clk <= ac0_src;
            aux1_clk <= ac1_src;
            aux1_dly <= aux1_clk;
        end
    end

    clk_divider u_netdiv (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(ac1_en),
        .divide(ac1_div),
        .src_level(aux1_clk),
        .src_rise(aux1_clk && !aux1_dly),
        .clk_out(network_clk)
    );

    // output clock: source mux, three-stage ripple taps, enable
    clock_gen_pkg::sel_code_t oc_act;
    logic oc_clk;
    logic oc_dly;
    logic [2:0] ripple;
    clock_gen_pkg::out_div_t oc_div_act;
    function automatic logic oc_level(input logic [3:0] c, input logic [4:0] lvl, input logic sysc);
        oc_level = (c == `SRC_XOSC) ? lvl[0] :
                   (c == `SRC_IRC) ? lvl[1] :
                   (c == `SRC_PLL) ? lvl[2] :
                   (c == `SRC_SYS) ? sysc :
                   (c == `SRC_RTC) ? lvl[4] : lvl[3];
    endfunction
    wire oc_src = oc_level(oc_act, src_lvl, system_clock);
    wire oc_new = oc_level(oc_sel, src_lvl, system_clock);
    wire [3:0] oc_taps = {ripple, oc_clk};
    // undivided tap follows the source, duty cycle not guaranteed
    wire oc_tap = oc_taps[oc_div_act];
    wire oc_tap_new = oc_taps[oc_output_divide_select_field];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_act <= `RST_SEL;
            oc_clk <= 1'b0;
            oc_dly <= 1'b0;
            ripple <= 3'h0;
            oc_div_act <= `RST_OUTPUT_DIVIDE_SELECT_FIELD;
            clock_output_pin <= 1'b0;
        end else if (ce) begin
            if (!oc_clk && !oc_src && !oc_new) begin
                oc_act <= oc_sel;
            end
            if (!oc_tap && !oc_tap_new) begin
                oc_div_act <= oc_output_divide_select_field;
            end
            oc_clk <= oc_src;
            oc_dly <= oc_clk;
            if (oc_clk && !oc_dly) begin
                ripple <= 3'(ripple + 3'h1);
            end
            clock_output_pin <= oc_en && oc_tap;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_safe_forces_irc: assert property ((safe_clock_req && ce) |=> sys_target == `SYS_IRC)
        else $error("safe request did not force internal RC");
    a_mask_holds_sel: assert property ((ce && !safe_clock_req && sys_switch_mask) |=> $stable(sys_target))
        else $error("system select changed while masked");
    a_sys_off_mode: assert property ((ce && !deep_stop_mode && !test_mode) |=> sys_status != `SYS_OFF)
        else $error("system clock off outside deep stop or test");
    a_aux0_keep_sel: assert property ((wr && hit_ac0 && !ac0_ok) |=> $stable(ac0_sel))
        else $error("reserved aux 0 code changed the register");
    a_aux1_take_sel: assert property ((wr && hit_ac1 && wsel == `AUX1_PHI1) |=> ac1_sel == `AUX1_PHI1)
        else $error("aux 1 select not stored");
    a_div_write_ignored: assert property ((wr && hit_acd && !wde) |=> !ac1_en && $stable(ac1_div))
        else $error("divide value written while disabled");
    a_net_clk_stopped: assert property ((ce && !ac1_en) ##1 (ce && !ac1_en) |=> !network_clk)
        else $error("network clock runs while divider disabled");
    a_oc_pin_off: assert property ((ce && !oc_en) |=> !clock_output_pin)
        else $error("output pin active while disabled");
endmodule

// File: mode_entry_model.sv
`timescale 1ns/100ps

module mode_entry_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] want_select,
    input wire logic want_safe,
    input wire logic want_off,
    input wire logic want_stop,
    input wire logic want_test,
    input wire logic want_mask,
    output logic [3:0] sys_select,
    output logic sys_switch_mask,
    output logic sys_clock_off,
    output logic deep_stop_mode,
    output logic test_mode,
    output logic safe_clock_req,
    output logic [4:0] src
);
    int cnt[5];
    // sources run free; periods 8,10,12,14,16 pclk so the sync stage sees every edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_select <= 4'h0;
            sys_switch_mask <= 1'h0;
            sys_clock_off <= 1'h0;
            deep_stop_mode <= 1'h0;
            test_mode <= 1'h0;
            safe_clock_req <= 1'h0;
            src <= 5'h00;
            for (int i = 0; i < 5; i++) cnt[i] <= 0;
        end else begin
            sys_select <= want_select;
            sys_switch_mask <= want_mask;
            deep_stop_mode <= want_stop;
            sys_clock_off <= want_off;
            test_mode <= want_test;
            safe_clock_req <= want_safe;
            for (int i = 0; i < 5; i++) begin
                cnt[i] <= (cnt[i] == 3 + i) ? 0 : cnt[i] + 1;
                if (cnt[i] == 3 + i) src[i] <= ~src[i];
            end
        end
    end
endmodule

// File: aux_and_system_clock_generation_tb.sv
`timescale 1ns/100ps
`include "clock_gen_cfg.svh"

module aux_and_system_clock_generation_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] want_select, sys_select;
    logic want_safe, want_off, sys_switch_mask, sys_clock_off, deep_stop_mode, test_mode, safe_clock_req;
    logic want_stop, want_test, want_mask;
    logic [4:0] src;
    logic system_clock, pll_reference_clk, network_clk, clock_output_pin;
    logic [2:0] periph_set_clk;
    logic [6:0] obs;
    int errors, tests_run, seed, p, h, d, sp;
    int per[4] = '{8, 10, 12, 0};
    logic [11:0] sdiv[3] = '{`OFS_SYS_DIVIDE_VALUE_FIELD, `OFS_SYS_DIV1, `OFS_SYS_DIV2};
    // 0 system, 1..3 peripheral sets, 4 pll reference, 5 network, 6 output pin
    assign obs = {clock_output_pin, network_clk, pll_reference_clk, periph_set_clk, system_clock};

    clock_generation_unit u_clock_generation_unit (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_crystal_osc(src[0]), .fast_internal_rc_osc(src[1]), .freq_modulated_pll(src[2]),
        .pll_secondary_output(src[3]), .rtc_clock(src[4]), .sys_select(sys_select),
        .sys_switch_mask(sys_switch_mask), .sys_clock_off(sys_clock_off), .deep_stop_mode(deep_stop_mode),
        .test_mode(test_mode), .safe_clock_req(safe_clock_req), .system_clock(system_clock),
        .periph_set_clk(periph_set_clk), .pll_reference_clk(pll_reference_clk), .network_clk(network_clk),
        .clock_output_pin(clock_output_pin));

    mode_entry_model u_mode_entry_model (.pclk(pclk), .presetn(presetn), .want_select(want_select),
        .want_safe(want_safe), .want_off(want_off), .want_stop(want_stop), .want_test(want_test),
        .want_mask(want_mask), .sys_select(sys_select), .sys_switch_mask(sys_switch_mask),
        .sys_clock_off(sys_clock_off), .deep_stop_mode(deep_stop_mode), .test_mode(test_mode),
        .safe_clock_req(safe_clock_req), .src(src));

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    task summarize;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task timeout;
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        summarize;
    endtask

    task check_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task check_clk(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // holds the request until pready is seen high, data taken at that edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) timeout;
    endtask

    // f: mask, test mode, deep stop, off request, safe request
    task mode(input logic [3:0] s, input logic [4:0] f);
        @(posedge pclk);
        want_select <= s;
        {want_mask, want_test, want_stop, want_off, want_safe} <= f;
    endtask

    // first period after a change may be stretched by the glitch-free switch, so it is skipped
    task period(input int idx, output int pr);
        int n, t0, e;
        logic prev;
        n = 0;
        e = 0;
        t0 = 0;
        prev = obs[idx];
        while (e < 3 && n < 4000) begin
            @(posedge pclk);
            #1;
            n++;
            if (obs[idx] === 1'h1 && prev === 1'h0) begin
                e++;
                if (e == 2) t0 = n;
            end
            prev = obs[idx];
        end
        pr = n - t0;
        if (e < 3) timeout;
    endtask

    task quiet(input int idx, output int hi);
        hi = 0;
        repeat (200) begin
            @(posedge pclk);
            #1;
            if (obs[idx] !== 1'h0) hi++;
        end
    endtask

    initial begin
        seed = 32'h9427;
        errors = 0;
        tests_run = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {want_select, want_safe, want_off, want_stop, want_test, want_mask} = '0;
        presetn = 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        foreach (sdiv[i]) begin
            apb(1'h0, sdiv[i], 32'h0);
            check_reg(rd, 32'h0);
        end
        apb(1'h0, 12'h390, 32'h0);
        check_reg({rd[30:0], er}, 32'h1);
        period(4, p);
        check_clk(p, 8);
        apb(1'h1, `OFS_AUX0_SEL, 32'h01000000);
        period(4, p);
        check_clk(p, 10);
        apb(1'h1, `OFS_AUX0_SEL, 32'h02000000);
        apb(1'h0, `OFS_AUX0_SEL, 32'h0);
        check_reg(rd, 32'h01000000);
        period(4, p);
        check_clk(p, 10);
        period(0, p);
        check_clk(p, 10);
        mode(`SYS_XOSC, 5'h00);
        period(0, p);
        check_clk(p, 8);
        mode(`SYS_XOSC, 5'h01);
        period(0, p);
        check_clk(p, 10);
        mode(`SYS_XOSC, 5'h06);
        repeat (10) @(posedge pclk);
        apb(1'h0, `OFS_SYS_STATUS, 32'h0);
        check_reg(rd & 32'h0F000000, 32'h0F000000);
        quiet(0, h);
        check_clk(h, 0);
        // off asked for outside deep stop and test is refused
        mode(`SYS_XOSC, 5'h02);
        period(0, p);
        check_clk(p, 8);
        apb(1'h0, `OFS_SYS_STATUS, 32'h0);
        check_reg(rd, {4'h0, `SYS_XOSC, 24'h000000});
        mode(`SYS_XOSC, 5'h0A);
        repeat (10) @(posedge pclk);
        quiet(0, h);
        check_clk(h, 0);
        // masked select is ignored, crystal stays
        mode(`SYS_PLL, 5'h10);
        period(0, p);
        check_clk(p, 8);
        mode(`SYS_PLL, 5'h00);
        sp = 12;
        per[3] = sp;
        period(0, p);
        check_clk(p, sp);
        foreach (sdiv[i]) begin
            d = $random(seed) & 3;
            apb(1'h1, sdiv[i], {1'h1, 3'h0, d[3:0], 24'h000000});
            period(i + 1, p);
            check_clk(p, (d + 1) * sp);
        end
        apb(1'h1, `OFS_AUX1_DIVIDE_VALUE_FIELD, 32'h03000000);
        apb(1'h0, `OFS_AUX1_DIVIDE_VALUE_FIELD, 32'h0);
        check_reg(rd, 32'h0);
        quiet(5, h);
        check_clk(h, 0);
        d = $random(seed) & 3;
        apb(1'h1, `OFS_AUX1_DIVIDE_VALUE_FIELD, {1'h1, 3'h0, d[3:0], 24'h000000});
        period(5, p);
        check_clk(p, (d + 1) * sp);
        // network clock gated before its source moves
        apb(1'h1, `OFS_AUX1_DIVIDE_VALUE_FIELD, 32'h0);
        apb(1'h1, `OFS_AUX1_SEL, 32'h01000000);
        apb(1'h1, `OFS_AUX1_DIVIDE_VALUE_FIELD, {1'h1, 3'h0, d[3:0], 24'h000000});
        period(5, p);
        check_clk(p, (d + 1) * 14);
        apb(1'h1, `OFS_AUX1_SEL, 32'h03000000);
        apb(1'h0, `OFS_AUX1_SEL, 32'h0);
        check_reg(rd, 32'h01000000);
        quiet(6, h);
        check_clk(h, 0);
        apb(1'h1, `OFS_OC_ENABLE, 32'h1);
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 4; v++) begin
                apb(1'h1, `OFS_OC_DIVSEL, {2'h0, v[1:0], s[3:0], 24'h000000});
                period(6, p);
                check_clk(p, per[s] << v);
            end
        end
        summarize;
    end
endmodule
